/* File: src/edge_finder.sv */
`timescale 1ns/100ps
module edge_finder #(
   parameter logic IDLE_LEVEL = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic level_in,
   output logic      rise,
   output logic      fall
);
   typedef struct packed {
      logic last;
   } edge_state_t;

   edge_state_t state_reg;
   edge_state_t state_next;

   always_comb begin
      state_next      = state_reg;
      state_next.last = level_in;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         // Starting from the pin's idle level avoids a false edge after reset
         state_reg <= '{last: IDLE_LEVEL};
      end else begin
         state_reg <= state_next;
      end
   end

   assign rise = level_in & ~state_reg.last;
   assign fall = ~level_in & state_reg.last;
endmodule : edge_finder

/* File: src/pin_sync.sv */
`timescale 1ns/100ps
module pin_sync #(
   parameter int unsigned WIDTH = 3
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] async_in,
   input  wire logic [WIDTH-1:0] reset_value,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
   } sync_state_t;

   sync_state_t state_reg;
   sync_state_t state_next;

   if (WIDTH < 1) begin : g_width_check
      $error("pin_sync needs WIDTH of at least one");
   end

   // Stages hold each pin XOR its idle level, so a plain zero reset reads back as idle
   always_comb begin
      state_next        = state_reg;
      state_next.stage1 = async_in ^ reset_value;
      state_next.stage2 = state_reg.stage1;
   end

   // Constant reset keeps the reset branch free of port values
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign sync_out = state_reg.stage2 ^ reset_value;
endmodule : pin_sync

/* File: src/temp_sensor_pkg.sv */
package temp_sensor_pkg;

   // Serial frame shape
   localparam int unsigned XMIT_BITS    = 16;
   localparam int unsigned RECV_BITS    = 8;
   localparam int unsigned FRAME_CLOCKS = 32;
   localparam int unsigned SYNC_STAGES  = 2;

   // Mode codes held in the low byte of the configuration word
   localparam logic [7:0] CODE_SHUTDOWN   = 8'hff;
   localparam logic [7:0] CODE_CONTINUOUS = 8'h00;

   // Temperature word layout
   localparam int unsigned TEMP_MSB      = 15;
   localparam int unsigned TEMP_LSB      = 2;
   localparam int unsigned TEMP_WIDTH    = 14;
   localparam logic [1:0]  TEMP_PAD_BITS = 2'h3;

   // Identification word layout; values are arbitrary
   localparam int unsigned MAKER_WIDTH   = 5;
   localparam int unsigned PART_WIDTH    = 11;
   localparam logic [4:0]  MAKER_CODE    = 5'h15;
   localparam logic [10:0] PART_CODE     = 11'h2a7;

   // Reset values
   localparam logic [13:0] TEMP_RESET    = 14'h0000;

   typedef enum logic [1:0] {
      MODE_CONTINUOUS = 2'b00,
      MODE_SHUTDOWN   = 2'b01,
      MODE_TEST       = 2'b11
   } op_mode_t;

   typedef enum logic [1:0] {
      LINK_IDLE = 2'b00,
      LINK_XMIT = 2'b01,
      LINK_RECV = 2'b11
   } link_state_t;

   typedef struct packed {
      logic cs_b;
      logic sclk;
      logic data;
   } link_pins_t;

   typedef struct packed {
      logic       valid;
      logic [TEMP_WIDTH-1:0] value;
   } temp_sample_t;

endpackage : temp_sensor_pkg

/* File: src/temp_sensor_regs.sv */
`timescale 1ns/100ps
// Summary of operation
// (RULE1) Configuration low byte all ones enters shutdown; upper byte ignored.
// (RULE2) Serial interface keeps working fully while in shutdown.
// (RULE3) In shutdown every read returns the fixed identification word.
// (RULE4) Identification word top five bits hold maker code, rest part code.
// (RULE5) Three registers only: temperature and ID readable, configuration write-only.
// (RULE6) All-zero configuration word selects continuous conversion mode.
// (RULE7) Host writes only shutdown or continuous codes; others enter test mode.
// (RULE8) Temperature word bits one and zero always sent as ones.
// (RULE9) Temperature bits fifteen to two: two's complement, 0.03125 C steps.
// (RULE10) Shutdown selects identification register for reads, else temperature.
// (RULE11) Frame is 32 clocks: 16 out to host, then 16 in.
// (RULE12) Output changes on falling clock edge, input sampled on rising.
// (RULE13) Received bits shift into eight-bit register; last eight count.
// (RULE14) Output sent most significant byte and bit first.
// (RULE15) New mode applied at chip select release; kept if under eight bits.
module temp_sensor_regs #(
   parameter int unsigned WORD_BITS = temp_sensor_pkg::XMIT_BITS
) (
   input  wire logic                  clk,
   input  wire logic                  rst_b,
   input  wire logic                  chip_select_b,
   input  wire logic                  serial_clock_in,
   input  wire logic                  data_in,
   output logic                       data_out,
   output logic                       data_oe_b,
   input  temp_sensor_pkg::temp_sample_t sample,
   output logic                       shutdown,
   output logic                       test_mode
);
   import temp_sensor_pkg::*;

   // Elaboration checks: the shift and count logic below is sized for this layout
   if (WORD_BITS != XMIT_BITS) begin : g_word_check
      $error("WORD_BITS must equal the transmit word width");
   end
   if (TEMP_WIDTH + $bits(TEMP_PAD_BITS) != WORD_BITS) begin : g_temp_check
      $error("temperature field and pad bits must fill the word");
   end
   if (TEMP_MSB != WORD_BITS - 1 || TEMP_MSB - TEMP_LSB + 1 != TEMP_WIDTH) begin : g_temp_pos
      $error("temperature field position does not match its width");
   end
   if (MAKER_WIDTH + PART_WIDTH != WORD_BITS) begin : g_id_check
      $error("identification fields must fill the word");
   end
   if (MAKER_WIDTH != $bits(MAKER_CODE) || PART_WIDTH != $bits(PART_CODE)) begin : g_code_check
      $error("identification codes must match their field widths");
   end
   // Receive counter is four bits wide and saturates at RECV_BITS
   if (RECV_BITS < 2 || RECV_BITS > 15) begin : g_recv_check
      $error("RECV_BITS must lie between 2 and 15");
   end
   // Clock counter is six bits wide and saturates at the end of the frame
   if (FRAME_CLOCKS != 2 * XMIT_BITS || FRAME_CLOCKS > 63) begin : g_frame_check
      $error("frame must be two words long and fit the clock counter");
   end
   if (SYNC_STAGES != 2) begin : g_sync_check
      $error("pin synchroniser has exactly two stages");
   end

   typedef struct packed {
      link_state_t           link;
      logic [5:0]            clk_count;
      logic [WORD_BITS-1:0]  out_shift;
      logic [RECV_BITS-1:0]  in_shift;
      logic [3:0]            in_count;
      logic                  out_bit;
      logic                  drive;
      op_mode_t              mode;
      logic [TEMP_WIDTH-1:0] temp_held;
   } regs_state_t;

   regs_state_t state_reg;
   regs_state_t state_next;

   logic [1:0] rst_sync_reg;
   logic       rst_int_b;
   link_pins_t pins_sync;
   link_pins_t pins_idle;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       cs_fall;
   logic       cs_rise;
   logic [WORD_BITS-1:0] temp_word;
   logic [WORD_BITS-1:0] id_word;
   logic [WORD_BITS-1:0] load_word;

   // Reset released through two flops; asserts at once
   // Kept apart from the state struct: it is the only register reset by the raw pin
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_int_b = rst_sync_reg[1];

   assign pins_idle = '{cs_b: 1'b1, sclk: 1'b0, data: 1'b0};

   // Serial clock is sampled, not used as a clock, so it must stay below clk/4
   pin_sync #(
      .WIDTH (3)
   ) u_pin_sync (
      .clk         (clk),
      .rst_b       (rst_int_b),
      .async_in    ({chip_select_b, serial_clock_in, data_in}),
      .reset_value (pins_idle),
      .sync_out    (pins_sync)
   );

   edge_finder u_sclk_edge (
      .clk      (clk),
      .rst_b    (rst_int_b),
      .level_in (pins_sync.sclk),
      .rise     (sclk_rise),
      .fall     (sclk_fall)
   );

   edge_finder #(
      .IDLE_LEVEL (1'b1)
   ) u_cs_edge (
      .clk      (clk),
      .rst_b    (rst_int_b),
      .level_in (pins_sync.cs_b),
      .rise     (cs_rise),
      .fall     (cs_fall)
   );

   assign temp_word = {state_reg.temp_held, TEMP_PAD_BITS};                      // (RULE8) (RULE9)
   assign id_word   = {MAKER_CODE, PART_CODE};                                   // (RULE4)
   assign load_word = (state_reg.mode == MODE_SHUTDOWN) ? id_word : temp_word;   // (RULE3) (RULE10)

   always_comb begin
      state_next          = state_reg;

      // Latest finished conversion is kept; a frame in flight still shifts its snapshot
      if (sample.valid) begin
         state_next.temp_held = sample.value;                                    // (RULE9)
      end

      case (state_reg.link)
         LINK_IDLE: begin
            state_next.drive = 1'b0;
            if (cs_fall) begin
               // First bit appears as soon as chip select drops
               state_next.link      = LINK_XMIT;
               state_next.clk_count = 6'd0;
               state_next.out_bit   = load_word[WORD_BITS-1];                    // (RULE14)
               state_next.out_shift = {load_word[WORD_BITS-2:0], 1'b0};
               state_next.in_count  = 4'd0;
               state_next.drive     = 1'b1;                                      // (RULE2)
            end
         end
         LINK_XMIT: begin
            if (sclk_rise) begin
               state_next.clk_count = state_reg.clk_count + 6'd1;
               if (state_reg.clk_count == 6'(XMIT_BITS - 1)) begin
                  state_next.link  = LINK_RECV;                                  // (RULE11)
                  state_next.drive = 1'b0;
               end
            end else if (sclk_fall && state_reg.clk_count != 6'd0) begin
               state_next.out_bit   = state_reg.out_shift[WORD_BITS-1];          // (RULE12) (RULE14)
               state_next.out_shift = {state_reg.out_shift[WORD_BITS-2:0], 1'b0};
            end
         end
         LINK_RECV: begin
            // Extra clocks past the frame keep shifting; only the last eight count
            if (sclk_rise) begin
               state_next.in_shift = {state_reg.in_shift[RECV_BITS-2:0],
                                      pins_sync.data};                           // (RULE12) (RULE13)
               if (state_reg.in_count != 4'(RECV_BITS)) begin
                  state_next.in_count = state_reg.in_count + 4'd1;
               end
               if (state_reg.clk_count != 6'(FRAME_CLOCKS)) begin
                  state_next.clk_count = state_reg.clk_count + 6'd1;             // (RULE11)
               end
            end
         end
         default: begin
            state_next.link  = LINK_IDLE;
            state_next.drive = 1'b0;
         end
      endcase

      // Chip select high ends any frame at once and commits a full byte
      if (cs_rise) begin
         state_next.link  = LINK_IDLE;
         state_next.drive = 1'b0;
         if (state_reg.link == LINK_RECV && state_reg.in_count == 4'(RECV_BITS)) begin // (RULE15)
            if (state_reg.in_shift == CODE_SHUTDOWN) begin
               state_next.mode = MODE_SHUTDOWN;                                  // (RULE1)
            end else if (state_reg.in_shift == CODE_CONTINUOUS) begin
               state_next.mode = MODE_CONTINUOUS;                                // (RULE6)
            end else begin
               state_next.mode = MODE_TEST;                                      // (RULE7)
            end
         end
      end
   end

   // Configuration is write-only: nothing reads the mode back over the wire
   always_ff @(posedge clk or negedge rst_int_b) begin
      if (!rst_int_b) begin
         state_reg.link      <= LINK_IDLE;
         state_reg.clk_count <= 6'd0;
         state_reg.out_shift <= '0;
         state_reg.in_shift  <= '0;
         state_reg.in_count  <= 4'd0;
         state_reg.out_bit   <= 1'b0;
         state_reg.drive     <= 1'b0;
         state_reg.mode      <= MODE_CONTINUOUS;
         state_reg.temp_held <= TEMP_RESET;
      end else begin
         state_reg.link      <= state_next.link;
         state_reg.clk_count <= state_next.clk_count;
         state_reg.out_shift <= state_next.out_shift;
         state_reg.in_shift  <= state_next.in_shift;
         state_reg.in_count  <= state_next.in_count;
         state_reg.out_bit   <= state_next.out_bit;
         state_reg.drive     <= state_next.drive;
         state_reg.mode      <= state_next.mode;
         state_reg.temp_held <= state_next.temp_held;
      end
   end

   // Test mode stops the device answering: line stays released
   assign data_out  = state_reg.out_bit;                                         // (RULE5)
   assign data_oe_b = ~(state_reg.drive && state_reg.mode != MODE_TEST);        // (RULE7)
   assign shutdown  = (state_reg.mode == MODE_SHUTDOWN);
   assign test_mode = (state_reg.mode == MODE_TEST);

endmodule : temp_sensor_regs

/* File: testbench/host_model.sv */
`timescale 1ns/100ps
module host_model (
   input  wire logic                 clk,
   input  wire logic                 data_out,
   input  wire logic                 data_oe_b,
   output temp_sensor_pkg::link_pins_t pins,
   output logic [15:0]               rdata,
   output logic                      done
);
   import temp_sensor_pkg::*;
   link_pins_t drv;
   logic       hen;
   logic       junk;
   logic       line;
   // Released line shows a toggling pattern, except while hen is set and the host drives the write bits
   assign line = !data_oe_b ? data_out : (hen ? drv.data : junk);
   assign pins = {drv.cs_b, drv.sclk, line};
   initial begin
      drv = 3'b100;
      hen = 1'b0;
      junk = 1'b0;
      rdata = '0;
      done = 1'b0;
   end
   always @(negedge clk) junk <= ~junk;
   task automatic wait_n(input int k);
      repeat (k) @(negedge clk);
   endtask : wait_n
   task automatic frame(input int nr, input int nw, input logic [15:0] wd);
      int n;
      n = (nr < 16) ? nr : 16 + nw;
      rdata = '0;
      drv.cs_b = 1'b0;
      wait_n(8);
      for (int i = 0; i < n; i++) begin
         hen = (i >= 16);
         if (i >= 16) drv.data = wd[15 + nw - i];
         wait_n(4);
         drv.sclk = 1'b1;
         wait_n(2);
         // Sampled mid-high so the bit launched at the fall has settled
         if (i < nr) rdata = {rdata[14:0], line};
         wait_n(2);
         drv.sclk = 1'b0;
      end
      wait_n(4);
      drv.cs_b = 1'b1;
      hen = 1'b0;
      wait_n(8);
      done = 1'b1;
      wait_n(1);
      done = 1'b0;
   endtask : frame
endmodule : host_model

/* File: testbench/temp_sensor_regs_properties.sv */
`timescale 1ns/100ps
module temp_sensor_checker (
   input wire logic                    clk,
   input wire logic                    rst_b,
   input wire logic                    chip_select_b,
   input wire logic                    serial_clock_in,
   input wire logic                    data_in,
   input wire logic                    data_out,
   input wire logic                    data_oe_b,
   input temp_sensor_pkg::temp_sample_t sample,
   input wire logic                    shutdown,
   input wire logic                    test_mode
);
   import temp_sensor_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence cs_open;
      $fell(chip_select_b) && !test_mode ##1 !chip_select_b [*6];
   endsequence
   sequence id_open;
      shutdown && $fell(data_oe_b);
   endsequence
   oe_start_a: assert property (cs_open |-> !data_oe_b)
      else $error("line not driven after select");
   oe_release_a: assert property (chip_select_b [*6] |-> data_oe_b)
      else $error("line driven while deselected");
   test_silent_a: assert property (test_mode |-> data_oe_b)
      else $error("line driven in test mode");
   mode_hold_a: assert property ($changed(shutdown) |-> chip_select_b)
      else $error("mode changed inside a frame");
   test_hold_a: assert property ($rose(test_mode) |-> $past(chip_select_b, 2))
      else $error("test mode entered inside a frame");
   bit_hold_a: assert property ($rose(serial_clock_in) && !data_oe_b
      |-> ##2 (data_oe_b || $stable(data_out)) [*3]) else $error("bit moved after rise");
   id_first_a: assert property (id_open |=> data_out == MAKER_CODE[4])
      else $error("wrong first bit of identification");
   shut_clean_a: assert property ($rose(shutdown) |-> !test_mode && data_oe_b)
      else $error("shutdown code entered test mode");
endmodule : temp_sensor_checker
bind temp_sensor_regs temp_sensor_checker chk (.clk(clk), .rst_b(rst_b),
   .chip_select_b(chip_select_b), .serial_clock_in(serial_clock_in), .data_in(data_in),
   .data_out(data_out), .data_oe_b(data_oe_b), .sample(sample), .shutdown(shutdown),
   .test_mode(test_mode));

/* File: testbench/temp_sensor_regs_test.sv */
`timescale 1ns/100ps
module temp_sensor_regs_test;
   import temp_sensor_pkg::*;
   localparam logic [15:0] ID_WORD = {MAKER_CODE, PART_CODE};
   logic         clk;
   logic         rst_b;
   link_pins_t   pins;
   logic         data_out;
   logic         data_oe_b;
   temp_sample_t sample;
   logic         shutdown;
   logic         test_mode;
   logic [15:0]  rdata;
   logic         done;
   logic [15:0]  exp_q[$];
   logic [15:0]  tw;
   int           n_fail = 0;
   int           cmp_count = 0;
   int           cycles = 0;
   temp_sensor_regs DUT (.clk(clk), .rst_b(rst_b), .chip_select_b(pins.cs_b),
      .serial_clock_in(pins.sclk), .data_in(pins.data), .data_out(data_out),
      .data_oe_b(data_oe_b), .sample(sample), .shutdown(shutdown), .test_mode(test_mode));
   host_model host (.clk(clk), .data_out(data_out), .data_oe_b(data_oe_b), .pins(pins),
      .rdata(rdata), .done(done));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   // Short reads keep only the leading bits, so the note is shifted to match
   task automatic xfer(input int nr, input int nw, input logic [15:0] wd,
                       input logic [15:0] ex, input logic chk);
      if (chk) exp_q.push_back(ex >> (16 - nr));
      host.frame(nr, nw, wd);
   endtask : xfer
   task automatic mode(input logic s, input logic t);
      check({13'h0, data_oe_b, shutdown, test_mode}, {13'h0, 1'b1, s, t});
   endtask : mode
   always @(posedge clk) begin
      if (done === 1'b1 && exp_q.size() > 0) check(rdata, exp_q.pop_front());
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         conclude();
      end
   end
   initial begin
      rst_b = 1'b0;
      sample = '0;
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      repeat (8) @(negedge clk);
      void'($urandom(32'hfe43cd7d));
      mode(1'b0, 1'b0);
      sample.value = 14'($urandom);
      sample.valid = 1'b1;
      @(negedge clk);
      sample.valid = 1'b0;
      tw = {sample.value, 2'h3};
      xfer(16, 16, 16'h0000, tw, 1'b1);
      xfer(4, 0, 16'h0000, tw, 1'b1);
      xfer(16, 16, 16'h5aff, tw, 1'b1);
      mode(1'b1, 1'b0);
      xfer(16, 4, 16'h0000, ID_WORD, 1'b1);
      mode(1'b1, 1'b0);
      xfer(16, 8, 16'h0000, ID_WORD, 1'b1);
      mode(1'b0, 1'b0);
      xfer(16, 8, 16'h005a, tw, 1'b1);
      mode(1'b0, 1'b1);
      xfer(16, 8, 16'h00ff, tw, 1'b0);
      mode(1'b1, 1'b0);
      xfer(16, 16, 16'hff00, ID_WORD, 1'b1);
      mode(1'b0, 1'b0);
      xfer(16, 8, 16'h00ff, tw, 1'b1);
      mode(1'b1, 1'b0);
      // Reset in mid-run must fall back to continuous mode and the reset reading
      rst_b = 1'b0;
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      repeat (8) @(negedge clk);
      mode(1'b0, 1'b0);
      xfer(16, 0, 16'h0000, {TEMP_RESET, 2'h3}, 1'b1);
      check(16'(exp_q.size()), 16'h0000);
      conclude();
   end
endmodule : temp_sensor_regs_test
